// *** rtl/osc_cfg.svh ***
/*
  constants of the otp security control block: offsets, field positions,
  reset values and the array geometry. assumes nothing of its surroundings.
*/
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
// ----------------------------------------
// array geometry
// ----------------------------------------
`define OSC_SEC_ROWS 512
`define OSC_MAIN_ROWS 2048
`define OSC_SECW_ROW 12'h7ff
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OSC_OFF_SEC 8'h00
`define OSC_OFF_ADDR 8'h04
`define OSC_OFF_DATA 8'h08
`define OSC_OFF_CTRL 8'h0c
`define OSC_OFF_STAT 8'h10
`define OSC_OFF_RDAT 8'h14
`define OSC_OFF_UCODE 8'h18
`define OSC_OFF_IDCODE 8'h1c
`define OSC_OFF_ID_ADDR 8'h20
`define OSC_OFF_ID_DATA 8'h24
`define OSC_OFF_ID_CTRL 8'h28
// ----------------------------------------
// port resource identifiers
// ----------------------------------------
`define OSC_RID_ADDR 24'h10_0200
`define OSC_RID_DATA 24'h20_0100
`define OSC_RID_CTRL 24'h10_0300
// ----------------------------------------
// security word fields and control bits
// ----------------------------------------
`define OSC_B_JTAG_DIS 0
`define OSC_B_LINK_DIS 1
`define OSC_B_SEC_BOOT 5
`define OSC_B_RED_EN 7
`define OSC_B_SLOCK0 8
`define OSC_B_MLOCK 12
`define OSC_B_JOTP_DIS 13
`define OSC_B_GP_LO 15
`define OSC_B_GP_HI 21
`define OSC_B_UID_LO 22
`define OSC_SEC_RST 32'hffff_ffff
`define OSC_C_PROG 0
`define OSC_C_READ 1
`endif

// *** rtl/osc_pkg.sv ***
/*
  types shared by the otp security control block.
  assumes osc_cfg.svh sits beside it.
*/
package osc_pkg;
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_LOADW = 3'b001,
    ST_COPY = 3'b010,
    ST_IDLE = 3'b011,
    ST_ACC = 3'b100
  } osc_state_t;

  typedef struct packed {
    logic en;
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
  } osc_mem_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } osc_jtag_req_t;
endpackage

// *** rtl/osc_otp_mem.sv ***
/*
  otp array model: one port, registered read data, writes only set bits.
  assumes the caller never addresses a row at or above ROWS.
*/
module osc_otp_mem
  import osc_pkg::*;
#(
  parameter int ROWS = 2052
) (
  // clock
  input wire logic sys_clk_i,
  // access
  input wire osc_mem_req_t req_i,
  output logic [31:0] rdata_o
);
  // blank fuses read as zero; the initial value keeps the write process the only driver
  logic [31:0] mem_q [ROWS] = '{default: 32'h0000_0000};

  if (ROWS > 4096) begin : g_chk
    $error("osc_otp_mem: ROWS exceeds 12-bit address");
  end

  always_ff @(posedge sys_clk_i) begin
    if (req_i.en && req_i.we) begin
      // RL19 fuses only set
      mem_q[req_i.addr] <= mem_q[req_i.addr] | req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (req_i.en) begin
      rdata_o <= mem_q[req_i.addr];
    end
  end
endmodule // osc_otp_mem

// *** rtl/osc_top.sv ***
/*
  otp access and security configuration for one tile: loads the security
  word at start-up, copies otp to sram, gates jtag and link access, and
  serves programming through the address, data and control ports over apb.
  assumes the chip tap logic and sram run on sys_clk_i.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
// Summary of operation
// RL1 - four sectors of 512 32-bit rows
// RL2 - security word loaded before it governs
// RL3 - remaining otp copied to sram, runs first
// RL4 - 16-bit row address port, id 0x100200
// RL5 - 32-bit program data port, id 0x200100
// RL6 - 16-bit control port, id 0x100300
// RL7 - bit 0 disables jtag
// RL8 - bit 1 refuses link access to state
// RL9 - bit 5 boots from otp address zero
// RL10 - bit 7 enables redundant rows
// RL11 - bits 8..11 lock sectors 0..3
// RL12 - bit 12 locks all programming
// RL13 - bit 13 blocks jtag otp access
// RL14 - bits 21..15 software security field
// RL15 - bits 31..22 into usercode user id
// RL16 - idcode returns identification value
// RL17 - bit 5 clear boots from flash
// RL18 - locked writes dropped silently
// RL19 - programmed bits never clear
module osc_top
  import osc_pkg::*;
#(
  parameter int RED_ROWS = 4,
  parameter int COPY_ROWS = 2047,
  // identification values are arbitrary
  parameter logic [31:0] IDCODE = 32'h0000_0001,
  parameter logic [21:0] UCODE_LOW = 22'h00_0000
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // chip tap otp access
  input wire osc_jtag_req_t jtag_req_i,
  output logic jtag_ack_o,
  output logic [31:0] jtag_rdata_o,
  output logic jtag_en_o,
  output logic [31:0] idcode_o,
  output logic [31:0] usercode_o,
  // switch access to processor state
  input wire logic link_req_i,
  output logic link_grant_o,
  output logic link_deny_o,
  // boot and sram load
  output logic sram_we_o,
  output logic [10:0] sram_addr_o,
  output logic [31:0] sram_wdata_o,
  output logic core_start_o,
  output logic boot_otp_o,
  output logic sec_ready_o,
  output logic [6:0] gp_field_o
);
  `include "osc_cfg.svh"

  localparam int ROWS = `OSC_MAIN_ROWS + RED_ROWS;

  if (RED_ROWS < 0 || RED_ROWS > 16 || COPY_ROWS < 1 || COPY_ROWS > 2047) begin : g_chk
    $error("osc_top: RED_ROWS or COPY_ROWS out of range");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // RL1 RL10 row decode
  function automatic logic row_ok(input logic [15:0] a, input logic [31:0] s);
    row_ok = (a < 16'(`OSC_MAIN_ROWS))
      || (s[`OSC_B_RED_EN] && (a < 16'(ROWS)));
  endfunction

  // RL11 RL12 RL18 lock decode
  function automatic logic prog_ok(input logic [15:0] a, input logic [31:0] s);
    logic sl;
    sl = (a < 16'(`OSC_MAIN_ROWS)) && s[`OSC_B_SLOCK0 + int'(a[10:9])];
    prog_ok = row_ok(a, s) && !s[`OSC_B_MLOCK] && !sl;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  osc_state_t state_q;
  logic [11:0] ptr_q;
  logic [31:0] sec_q;
  logic sec_vld_q;
  logic [15:0] addr_q;
  logic [31:0] data_q;
  logic [15:0] ctrl_q;
  logic pend_q;
  logic src_jtag_q;
  logic blk_q;
  logic [31:0] rd_word_q;
  logic cp_vld_q;
  logic [10:0] cp_addr_q;
  logic start_q;
  logic jtag_en_q;
  logic jack_q;
  logic [31:0] jrd_q;
  logic [31:0] prdata_q;
  osc_mem_req_t mreq;
  logic [31:0] mrdata;
  logic issue_apb;
  logic issue_jtag;
  logic jtag_blk;
  logic apb_wr;
  logic mapped;

  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign issue_apb = (state_q == ST_IDLE) && pend_q;
  assign issue_jtag = (state_q == ST_IDLE) && !pend_q && jtag_req_i.req && !jack_q;
  // RL7 RL13 tap locked out of otp
  assign jtag_blk = sec_q[`OSC_B_JOTP_DIS] || sec_q[`OSC_B_JTAG_DIS];

  // ----------------------------------------
  // otp array port
  // ----------------------------------------
  always_comb begin
    mreq = '0;
    case (state_q)
      ST_LOAD: begin
        mreq.en = 1'b1;
        mreq.addr = `OSC_SECW_ROW;
      end
      ST_COPY: begin
        mreq.en = 1'b1;
        mreq.addr = ptr_q;
      end
      ST_IDLE: begin
        if (issue_apb && row_ok(addr_q, sec_q)) begin
          mreq.en = ctrl_q[`OSC_C_READ] || prog_ok(addr_q, sec_q);
          mreq.we = ctrl_q[`OSC_C_PROG] && prog_ok(addr_q, sec_q);
          mreq.addr = addr_q[11:0];
          mreq.wdata = data_q;
        end else if (issue_jtag && !jtag_blk && row_ok(jtag_req_i.addr, sec_q)) begin
          mreq.en = !jtag_req_i.we || prog_ok(jtag_req_i.addr, sec_q);
          mreq.we = jtag_req_i.we && prog_ok(jtag_req_i.addr, sec_q);
          mreq.addr = jtag_req_i.addr[11:0];
          mreq.wdata = jtag_req_i.wdata;
        end
      end
      default: mreq = '0;
    endcase
  end

  osc_otp_mem #(
    .ROWS(ROWS)
  ) osc_otp_mem_i (
    .sys_clk_i(sys_clk_i),
    .req_i(mreq),
    .rdata_o(mrdata)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_q <= ST_LOAD;
      ptr_q <= 12'h000;
    end else begin
      case (state_q)
        ST_LOAD: state_q <= ST_LOADW;
        ST_LOADW: state_q <= ST_COPY;
        // RL3 copy rows 0 to COPY_ROWS-1, all rows below the security word at the default 2047
        ST_COPY: begin
          ptr_q <= ptr_q + 12'h001;
          if (ptr_q == 12'(COPY_ROWS - 1)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (issue_apb || issue_jtag) begin
            state_q <= ST_ACC;
          end
        end
        ST_ACC: state_q <= ST_IDLE;
        default: state_q <= ST_LOAD;
      endcase
    end
  end

  // RL2 security word taken before anything is granted
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sec_q <= `OSC_SEC_RST;
      sec_vld_q <= 1'b0;
    end else if (state_q == ST_LOADW) begin
      sec_q <= mrdata;
      sec_vld_q <= 1'b1;
    end
  end

  // sram load stream lags the array read by one cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cp_vld_q <= 1'b0;
      cp_addr_q <= 11'h000;
      start_q <= 1'b0;
    end else begin
      cp_vld_q <= (state_q == ST_COPY);
      cp_addr_q <= ptr_q[10:0];
      // RL3 core starts only once the copy has landed
      if (state_q == ST_IDLE && !cp_vld_q) begin
        start_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  always_comb begin
    case (paddr_i)
      `OSC_OFF_SEC, `OSC_OFF_ADDR, `OSC_OFF_DATA, `OSC_OFF_CTRL,
      `OSC_OFF_STAT, `OSC_OFF_RDAT, `OSC_OFF_UCODE, `OSC_OFF_IDCODE,
      `OSC_OFF_ID_ADDR, `OSC_OFF_ID_DATA, `OSC_OFF_ID_CTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      addr_q <= 16'h0000;
      data_q <= 32'h0000_0000;
    end else if (apb_wr) begin
      // RL4 address port
      if (paddr_i == `OSC_OFF_ADDR) begin
        addr_q <= pwdata_i[15:0];
      end
      // RL5 data port
      if (paddr_i == `OSC_OFF_DATA) begin
        data_q <= pwdata_i;
      end
    end
  end

  // a command written while one is pending, or before the security word is loaded, is dropped
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q <= 16'h0000;
      pend_q <= 1'b0;
    end else if (state_q == ST_ACC && !src_jtag_q) begin
      pend_q <= 1'b0;
    end else if (apb_wr && paddr_i == `OSC_OFF_CTRL && !pend_q && sec_vld_q) begin
      // RL6 control port launches the operation
      ctrl_q <= pwdata_i[15:0];
      pend_q <= pwdata_i[`OSC_C_PROG] || pwdata_i[`OSC_C_READ];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      src_jtag_q <= 1'b0;
      blk_q <= 1'b0;
      rd_word_q <= 32'h0000_0000;
    end else begin
      if (issue_apb) begin
        src_jtag_q <= 1'b0;
        blk_q <= !row_ok(addr_q, sec_q);
      end else if (issue_jtag) begin
        src_jtag_q <= 1'b1;
        blk_q <= jtag_blk || !row_ok(jtag_req_i.addr, sec_q);
      end
      if (state_q == ST_ACC && !src_jtag_q && ctrl_q[`OSC_C_READ]) begin
        rd_word_q <= blk_q ? 32'h0000_0000 : mrdata;
      end
    end
  end

  // read data is captured in the setup phase, ready with no wait states
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      case (paddr_i)
        // RL14 software sees the whole word
        `OSC_OFF_SEC: prdata_q <= sec_q;
        `OSC_OFF_ADDR: prdata_q <= {16'h0000, addr_q};
        `OSC_OFF_DATA: prdata_q <= data_q;
        `OSC_OFF_CTRL: prdata_q <= {16'h0000, ctrl_q};
        `OSC_OFF_STAT: prdata_q <= {28'h000_0000, boot_otp_o, start_q, sec_vld_q, pend_q};
        `OSC_OFF_RDAT: prdata_q <= rd_word_q;
        `OSC_OFF_UCODE: prdata_q <= usercode_o;
        `OSC_OFF_IDCODE: prdata_q <= IDCODE;
        `OSC_OFF_ID_ADDR: prdata_q <= {8'h00, `OSC_RID_ADDR};
        `OSC_OFF_ID_DATA: prdata_q <= {8'h00, `OSC_RID_DATA};
        `OSC_OFF_ID_CTRL: prdata_q <= {8'h00, `OSC_RID_CTRL};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // tap and link side
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      jack_q <= 1'b0;
      jrd_q <= 32'h0000_0000;
      jtag_en_q <= 1'b0;
    end else begin
      jack_q <= (state_q == ST_ACC) && src_jtag_q;
      if (state_q == ST_ACC && src_jtag_q) begin
        // RL13 blocked reads return zero, no error
        jrd_q <= blk_q ? 32'h0000_0000 : mrdata;
      end
      // RL7 tap disabled by bit 0
      jtag_en_q <= sec_vld_q && !sec_q[`OSC_B_JTAG_DIS];
    end
  end

  // RL8 switch requests refused
  assign link_grant_o = link_req_i && sec_vld_q && !sec_q[`OSC_B_LINK_DIS];
  assign link_deny_o = link_req_i && !link_grant_o;

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign jtag_ack_o = jack_q;
  assign jtag_rdata_o = jrd_q;
  assign jtag_en_o = jtag_en_q;
  // RL16 identification value
  assign idcode_o = IDCODE;
  // RL15 user id field, zero until loaded
  assign usercode_o = {sec_vld_q ? sec_q[31:`OSC_B_UID_LO] : 10'h000, UCODE_LOW};
  assign sram_we_o = cp_vld_q;
  assign sram_addr_o = cp_addr_q;
  assign sram_wdata_o = mrdata;
  assign core_start_o = start_q;
  // RL9 RL17 boot source select
  assign boot_otp_o = sec_vld_q && sec_q[`OSC_B_SEC_BOOT];
  assign sec_ready_o = sec_vld_q;
  assign gp_field_o = sec_q[`OSC_B_GP_HI:`OSC_B_GP_LO];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_jtag_off;
    sec_vld_q && sec_q[`OSC_B_JTAG_DIS] |=> !jtag_en_o;
  endproperty
  a_jtag_off: assert property (p_jtag_off) else $error("tap enabled with bit 0 set"); // RL7

  property p_link_refuse;
    link_req_i && sec_q[`OSC_B_LINK_DIS] |-> !link_grant_o && link_deny_o;
  endproperty
  a_link_refuse: assert property (p_link_refuse) else $error("link granted with bit 1 set"); // RL8

  property p_load_first;
    link_grant_o || jtag_en_o || mreq.we |-> sec_vld_q;
  endproperty
  a_load_first: assert property (p_load_first) else $error("access before security load"); // RL2

  property p_lock;
    mreq.we |-> prog_ok({4'h0, mreq.addr}, sec_q) && !sec_q[`OSC_B_MLOCK];
  endproperty
  a_lock: assert property (p_lock) else $error("write to locked row"); // RL11 RL12 RL18

  property p_red_rows;
    mreq.en && mreq.addr >= 12'(`OSC_MAIN_ROWS) |-> sec_q[`OSC_B_RED_EN];
  endproperty
  a_red_rows: assert property (p_red_rows) else $error("redundant row without bit 7"); // RL10

  property p_jtag_otp;
    mreq.en && issue_jtag |-> !sec_q[`OSC_B_JOTP_DIS] && !sec_q[`OSC_B_JTAG_DIS];
  endproperty
  a_jtag_otp: assert property (p_jtag_otp) else $error("tap reached otp while locked out"); // RL7 RL13

  property p_copy_first;
    $rose(core_start_o) |-> $past(state_q) == ST_IDLE && !sram_we_o;
  endproperty
  a_copy_first: assert property (p_copy_first) else $error("core started during copy"); // RL3

  property p_boot_stable;
    core_start_o |-> $stable(boot_otp_o);
  endproperty
  a_boot_stable: assert property (p_boot_stable) else $error("boot source moved"); // RL9 RL17

  sequence s_cmd;
    issue_apb;
  endsequence
  sequence s_done;
    state_q == ST_ACC ##1 !pend_q;
  endsequence
  property p_cmd;
    s_cmd |=> s_done;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command not completed in two cycles"); // RL6

  property p_addr_port;
    apb_wr && paddr_i == `OSC_OFF_ADDR |=> addr_q == $past(pwdata_i[15:0]);
  endproperty
  a_addr_port: assert property (p_addr_port) else $error("address port not loaded"); // RL4

  property p_uid;
    sec_vld_q |-> usercode_o[31:22] == sec_q[31:22];
  endproperty
  a_uid: assert property (p_uid) else $error("usercode user id mismatch"); // RL15
endmodule // osc_top

// *** test/osc_tap_host.sv ***
/*
  behavioural chip tap host that reaches the otp through the tap request port.
  assumes it shares sys_clk_i with the block and that callers enter just after a rising edge.
*/
module osc_tap_host
  import osc_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // answer from the block
  input wire logic jtag_ack_i,
  input wire logic [31:0] jtag_rdata_i,
  // request to the block
  output osc_jtag_req_t jtag_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // request handshake
  // ----------------------------------------
  initial jtag_req_o = '0;
  // held until the acknowledge is sampled, then dropped so it is not served twice
  task automatic access(input logic we, input logic [15:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
    int n;
    jtag_req_o <= '{req: 1'b1, we: we, addr: addr, wdata: wdata};
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (jtag_ack_i !== 1'b1 && n < 64);
    rdata = jtag_rdata_i;
    ok = (n < 64);
    // released fields carry the inverse so a stale value cannot pass
    jtag_req_o <= '{req: 1'b0, we: ~we, addr: ~addr, wdata: ~wdata};
    @(posedge sys_clk_i);
  endtask
endmodule // osc_tap_host

// *** test/osc_top_test.sv ***
/*
  self-checking bench for osc_top: apb master tasks, reset with copy watch, scenario tasks.
  assumes the otp array model starts blank and keeps its content across srst_i.
*/
`include "osc_cfg.svh"
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module osc_top_test
  import osc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // identification values are arbitrary
  localparam logic [31:0] ID_VAL = 32'h0000_0a5b;
  localparam logic [21:0] UC_LOW = 22'h01_2345;
  localparam logic [31:0] SW1 = {10'h2a5, 7'h55, 15'h02a2};
  localparam logic [31:0] SW2 = SW1 | 32'h0000_3001;
  logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, link_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, jtag_rdata, idcode, usercode, sram_wdata;
  logic pready, pslverr, jtag_ack, jtag_en, link_grant, link_deny, sram_we, core_start, boot_otp, sec_ready;
  logic [10:0] sram_addr;
  logic [6:0] gp_field;
  osc_jtag_req_t jreq;
  int n_errors = 0;
  int num_checks = 0;
  // ----------------------------------------
  // clock, instances, watchdog
  // ----------------------------------------
  initial forever #4 sys_clk = ~sys_clk;
  osc_top #(.COPY_ROWS(8), .IDCODE(ID_VAL), .UCODE_LOW(UC_LOW)) osc_top_i (
    .sys_clk_i(sys_clk), .srst_i(srst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .jtag_req_i(jreq), .jtag_ack_o(jtag_ack), .jtag_rdata_o(jtag_rdata), .jtag_en_o(jtag_en),
    .idcode_o(idcode), .usercode_o(usercode), .link_req_i(link_req), .link_grant_o(link_grant),
    .link_deny_o(link_deny), .sram_we_o(sram_we), .sram_addr_o(sram_addr), .sram_wdata_o(sram_wdata),
    .core_start_o(core_start), .boot_otp_o(boot_otp), .sec_ready_o(sec_ready), .gp_field_o(gp_field));
  osc_tap_host osc_tap_host_i (.sys_clk_i(sys_clk), .jtag_ack_i(jtag_ack), .jtag_rdata_i(jtag_rdata),
    .jtag_req_o(jreq));
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end
  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // apb master and otp helpers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      complete_run();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    `CHK(e, 1'b0, "error on mapped write")
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(`OSC_OFF_STAT, s);
      n++;
    end while (s[0] !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic prog(input logic [15:0] row, input logic [31:0] d);
    wr(`OSC_OFF_ADDR, {16'h0000, row});
    wr(`OSC_OFF_DATA, d);
    wr(`OSC_OFF_CTRL, 32'h0000_0001);
    wait_idle();
  endtask
  task automatic orow(input logic [15:0] row, output logic [31:0] r);
    wr(`OSC_OFF_ADDR, {16'h0000, row});
    wr(`OSC_OFF_CTRL, 32'h0000_0002);
    wait_idle();
    rd(`OSC_OFF_RDAT, r);
  endtask
  // reset, then watch the start-up copy of rows 0..7 into sram
  task automatic do_reset(input logic [31:0] w0);
    int n;
    srst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    `CHK(jtag_en, 1'b0, "tap enabled in reset")
    srst <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      if (sram_we === 1'b1) begin
        `CHK(sram_addr, 11'(n), "copy address")
        if (n == 0) `CHK(sram_wdata, w0, "copy data row 0")
        n++;
      end
    end
    `CHK(n, 8, "copy word count")
    `CHK({core_start, sec_ready}, 2'b11, "core not started")
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults;
    logic [31:0] r;
    logic e;
    rd(`OSC_OFF_SEC, r);
    `CHK(r, 32'h0000_0000, "blank security word")
    `CHK({jtag_en, boot_otp, gp_field}, 9'h100, "blank outputs")
    `CHK(usercode, {10'h000, UC_LOW}, "usercode blank")
    `CHK(idcode, ID_VAL, "idcode port")
    rd(`OSC_OFF_IDCODE, r);
    `CHK(r, ID_VAL, "idcode register")
    rd(`OSC_OFF_ID_ADDR, r);
    `CHK(r, {8'h00, `OSC_RID_ADDR}, "address port id")
    rd(`OSC_OFF_ID_DATA, r);
    `CHK(r, {8'h00, `OSC_RID_DATA}, "data port id")
    rd(`OSC_OFF_ID_CTRL, r);
    `CHK(r, {8'h00, `OSC_RID_CTRL}, "control port id")
    apb(1'b0, 8'h30, 32'h0000_0000, r, e);
    `CHK(e, 1'b1, "unmapped not refused")
    wr(`OSC_OFF_SEC, 32'hffff_ffff);
    rd(`OSC_OFF_SEC, r);
    `CHK(r, 32'h0000_0000, "read-only word written")
  endtask
  task automatic t_program;
    logic [31:0] r;
    logic ok;
    prog(16'h0005, 32'h0000_00f0);
    prog(16'h0005, 32'h0000_000f);
    prog(16'h0005, 32'h0000_0000);
    orow(16'h0005, r);
    `CHK(r, 32'h0000_00ff, "bits accumulate")
    osc_tap_host_i.access(1'b0, 16'h0005, 32'h0000_0000, r, ok);
    `CHK({ok, r}, {1'b1, 32'h0000_00ff}, "tap read")
    osc_tap_host_i.access(1'b1, 16'h0006, 32'h0000_1234, r, ok);
    `CHK(ok, 1'b1, "tap program not answered")
    orow(16'h0006, r);
    `CHK(r, 32'h0000_1234, "tap program")
    prog(16'h0800, 32'h0000_0005);
    orow(16'h0800, r);
    `CHK(r, 32'h0000_0000, "redundant row used unenabled")
    prog(16'h0000, 32'hcafe_0001);
  endtask
  task automatic t_security;
    logic [31:0] r;
    prog(16'h07ff, SW1);
    do_reset(32'hcafe_0001);
    rd(`OSC_OFF_SEC, r);
    `CHK(r, SW1, "security word load")
    `CHK({jtag_en, boot_otp, gp_field}, 9'h1d5, "boot and field")
    `CHK(usercode, {10'h2a5, UC_LOW}, "usercode user id")
    link_req <= 1'b1;
    @(posedge sys_clk);
    `CHK({link_grant, link_deny}, 2'b01, "link not refused")
    link_req <= 1'b0;
    prog(16'h01ff, 32'h0000_0001);
    orow(16'h01ff, r);
    `CHK(r, 32'h0000_0001, "sector 0 last row")
    prog(16'h0200, 32'h0000_0001);
    orow(16'h0200, r);
    `CHK(r, 32'h0000_0000, "sector 1 locked")
    prog(16'h0800, 32'h0000_0005);
    orow(16'h0800, r);
    `CHK(r, 32'h0000_0005, "redundant row")
  endtask
  task automatic t_master;
    logic [31:0] r;
    logic ok;
    `CHK(link_grant, 1'b0, "grant without request")
    prog(16'h07ff, SW2);
    do_reset(32'hcafe_0001);
    rd(`OSC_OFF_SEC, r);
    `CHK(r, SW2, "second load")
    `CHK(jtag_en, 1'b0, "tap still enabled")
    osc_tap_host_i.access(1'b0, 16'h0005, 32'h0000_0000, r, ok);
    `CHK({ok, r}, {1'b1, 32'h0000_0000}, "tap otp read blocked")
    prog(16'h0006, 32'hffff_0000);
    orow(16'h0006, r);
    `CHK(r, 32'h0000_1234, "master lock")
    prog(16'h07ff, 32'hffff_ffff);
    orow(16'h07ff, r);
    `CHK(r, SW2, "security word locked")
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset(32'h0000_0000);
    t_defaults();
    t_program();
    t_security();
    t_master();
    complete_run();
  end
endmodule // osc_top_test
